/* rtl/gpib_pkg.sv */
package gpib_pkg;
  // Primary and secondary byte prefixes
  localparam logic [2:0] LISTEN_PREFIX = 3'h1;
  localparam logic [2:0] TALK_PREFIX = 3'h2;
  localparam logic [2:0] SECONDARY_PREFIX = 3'h3;
  localparam logic [4:0] UNIVERSAL_ADDR = 5'h1F;
  localparam logic [7:0] UNLISTEN_BYTE = 8'h3F;
  localparam logic [7:0] UNTALK_BYTE = 8'h5F;
  localparam logic [7:0] CR_BYTE = 8'h0D;
  localparam logic [7:0] DIGIT_ZERO = 8'h30;
  localparam logic [7:0] DIGIT_NINE = 8'h39;
  // Secondary command codes
  localparam logic [4:0] CMD_STATUS = 5'h00;
  localparam logic [4:0] CMD_SAVE = 5'h01;
  localparam logic [4:0] CMD_CLOSE = 5'h02;
  localparam logic [4:0] CMD_LOAD_OR_APPEND = 5'h04;
  localparam logic [4:0] CMD_TYPE_QUERY = 5'h06;
  localparam logic [4:0] CMD_FILE_HEADER = 5'h07;
  localparam logic [4:0] CMD_PRINT = 5'h09;
  localparam logic [4:0] CMD_INPUT = 5'h0C;
  localparam logic [4:0] CMD_READ = 5'h0D;
  localparam logic [4:0] CMD_WRITE = 5'h0E;
  localparam logic [4:0] CMD_LISTEN = 5'h0F;
  localparam logic [4:0] CMD_FIND = 5'h18;
  localparam logic [4:0] CMD_MARK = 5'h19;
  localparam logic [4:0] CMD_PROTECT_FILE = 5'h1A;
  localparam logic [4:0] CMD_ERROR_QUERY = 5'h1B;
  localparam logic [4:0] CMD_SPARE_LO = 5'h1C;
  localparam logic [4:0] CMD_SPARE_HI = 5'h1E;
  // Talker FIFO shape
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  // Controller register map
  localparam logic [7:0] REG_TX_OFFSET = 8'h00;
  localparam logic [7:0] REG_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] REG_RX_OFFSET = 8'h08;
  localparam int TX_ATN_BIT = 8;
  localparam int TX_EOI_BIT = 9;
  localparam int ST_TX_BUSY_BIT = 0;
  localparam int ST_RX_VALID_BIT = 1;
  localparam int RX_EOI_BIT = 8;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
endpackage

/* rtl/gpib_link_if.sv */
`timescale 1ns/1ps
interface gpib_link_if;
  // Controller to drive bytes
  logic [7:0] ctl_data;
  logic ctl_atn;
  logic ctl_eoi;
  logic ctl_valid;
  logic dev_ready;
  // Drive to controller bytes
  logic [7:0] dev_data;
  logic dev_eoi;
  logic dev_valid;
  logic ctl_ready;
  modport controller (
    output ctl_data, ctl_atn, ctl_eoi, ctl_valid, ctl_ready,
    input dev_ready, dev_data, dev_eoi, dev_valid
  );
  modport drive (
    input ctl_data, ctl_atn, ctl_eoi, ctl_valid, ctl_ready,
    output dev_ready, dev_data, dev_eoi, dev_valid
  );
endinterface

/* rtl/talk_fifo.sv */
`timescale 1ns/1ps
module talk_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  logic full_reg;

  // Ready from a flop, so the fill side never sees a decode glitch
  assign in_ready = !full_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Full flag tracks the count one step ahead
  always_ff @(posedge clk) begin
    if (srst) begin
      full_reg <= 1'b0;
    end else if (push && !pop) begin
      full_reg <= (count_reg == (AW+1)'(DEPTH - 1));
    end else if (pop && !push) begin
      full_reg <= 1'b0;
    end
  end
endmodule

/* rtl/tape_drive_end.sv */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Address switches hold 1..30 binary
// - Addresses 0 and 31 never used
// - Compare addresses only under ATN
// - Listen address is 001 plus switches
// - Talk address is 010 plus switches
// - Talk sends data, listen accepts data
// - Controller sends address then secondary byte
// - Decode secondary codes 0..13; this design drops 3, 5, 8, 10 and 11
// - Decode codes 14..27, accept 28..30; this design drops 16..23
// - Parameter string follows after ATN released
// - Parameter ends on CR or EOI
// - Find passes file number to executor
// - Remote switch gates all bus control
// - Protocol switch honoured only with option
// - Talker flags final byte with EOI
// - Untalk/unlisten stops ongoing transfer
module tape_drive_end #(
  parameter bit HAS_PROTOCOL_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus side
  gpib_link_if.drive bus,
  // Switches, asynchronous pins
  input wire logic [4:0] device_address_switches,
  input wire logic remote_select_switch,
  input wire logic protocol_select_switch,
  // Command to tape executor
  output logic cmd_valid,
  output logic [4:0] cmd_code,
  output logic param_valid,
  output logic [15:0] param_value,
  // Listener data to executor
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  // File data from executor for talking
  input wire logic [7:0] talk_data,
  input wire logic talk_last,
  input wire logic talk_valid,
  output logic talk_ready,
  // Addressed state
  output logic is_talker,
  output logic is_listener
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SECONDARY = 3'b010,
    ST_PARAM = 3'b100
  } parse_state_type;

  parse_state_type state_reg;
  logic [6:0] sw_s1_reg, sw_s2_reg, sw_s3_reg;
  logic [6:0] sw_reg;
  logic talk_reg, listen_reg, prim_talk_reg;
  logic cmd_valid_reg, param_valid_reg, rx_valid_reg, rx_eoi_reg;
  logic [4:0] cmd_code_reg;
  logic [15:0] param_reg;
  logic [7:0] rx_data_reg;
  logic tx_valid_reg, tx_eoi_reg;
  logic [7:0] tx_data_reg;
  logic [8:0] fifo_out;
  logic fifo_valid, fifo_pop;
  logic bus_on, atn_byte, data_byte, tx_take;

  // Address byte from a three-bit prefix and the switch value
  function automatic logic [7:0] addr_byte(input logic [2:0] prefix, input logic [4:0] a);
    return {prefix, a};
  endfunction

  // Known secondary codes; 3, 5, 8, 10, 11, 16..23 and 31 are dropped
  function automatic logic known_code(input logic [4:0] c);
    case (c)
      gpib_pkg::CMD_STATUS, gpib_pkg::CMD_SAVE, gpib_pkg::CMD_CLOSE,
      gpib_pkg::CMD_LOAD_OR_APPEND, gpib_pkg::CMD_TYPE_QUERY,
      gpib_pkg::CMD_FILE_HEADER, gpib_pkg::CMD_PRINT, gpib_pkg::CMD_INPUT,
      gpib_pkg::CMD_READ: return 1'b1;
      gpib_pkg::CMD_WRITE, gpib_pkg::CMD_LISTEN, gpib_pkg::CMD_FIND,
      gpib_pkg::CMD_MARK, gpib_pkg::CMD_PROTECT_FILE,
      gpib_pkg::CMD_ERROR_QUERY: return 1'b1;
      default: return (c >= gpib_pkg::CMD_SPARE_LO) && (c <= gpib_pkg::CMD_SPARE_HI);
    endcase
  endfunction

  // Switch pins: three flops, value taken once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_s1_reg <= '0;
      sw_s2_reg <= '0;
      sw_s3_reg <= '0;
      sw_reg <= '0;
    end else begin
      sw_s1_reg <= {protocol_select_switch, remote_select_switch, device_address_switches};
      sw_s2_reg <= sw_s1_reg;
      sw_s3_reg <= sw_s2_reg;
      if (sw_s2_reg == sw_s3_reg) begin
        sw_reg <= sw_s3_reg;
      end
    end
  end

  // Bus is live only on line, and in this protocol when the option exists
  assign bus_on = sw_reg[5] && !(HAS_PROTOCOL_OPTION && sw_reg[6]);
  assign atn_byte = bus_on && bus.ctl_valid && bus.ctl_atn;
  assign data_byte = bus_on && bus.ctl_valid && !bus.ctl_atn;

  // Addressed state; a bad switch value (0 or 31) still decodes, controller must avoid it
  always_ff @(posedge clk) begin
    if (srst || !bus_on) begin
      talk_reg <= 1'b0;
      listen_reg <= 1'b0;
      prim_talk_reg <= 1'b0;
    end else if (atn_byte) begin
      if (bus.ctl_data == addr_byte(gpib_pkg::LISTEN_PREFIX, sw_reg[4:0])) begin
        listen_reg <= 1'b1;
        prim_talk_reg <= 1'b0;
      end else if (bus.ctl_data == addr_byte(gpib_pkg::TALK_PREFIX, sw_reg[4:0])) begin
        talk_reg <= 1'b1;
        prim_talk_reg <= 1'b1;
      end else if (bus.ctl_data == gpib_pkg::UNLISTEN_BYTE) begin
        listen_reg <= 1'b0;
      end else if (bus.ctl_data == gpib_pkg::UNTALK_BYTE) begin
        talk_reg <= 1'b0;
      end
    end
  end

  // Parse: my address, then secondary, then optional parameter string
  always_ff @(posedge clk) begin
    if (srst || !bus_on) begin
      state_reg <= ST_IDLE;
    end else if (atn_byte) begin
      if (bus.ctl_data == addr_byte(gpib_pkg::LISTEN_PREFIX, sw_reg[4:0]) ||
          bus.ctl_data == addr_byte(gpib_pkg::TALK_PREFIX, sw_reg[4:0])) begin
        state_reg <= ST_SECONDARY;
      end else if (state_reg == ST_SECONDARY &&
                   bus.ctl_data[7:5] == gpib_pkg::SECONDARY_PREFIX &&
                   known_code(bus.ctl_data[4:0]) && !prim_talk_reg) begin
        state_reg <= ST_PARAM;
      end else begin
        state_reg <= ST_IDLE;
      end
    end else if (data_byte && state_reg == ST_PARAM &&
                 (bus.ctl_eoi || bus.ctl_data == gpib_pkg::CR_BYTE || !listen_reg)) begin
      state_reg <= ST_IDLE;
    end else if (data_byte && state_reg == ST_SECONDARY) begin
      state_reg <= ST_IDLE;
    end
  end

  // Command strobe on a decoded secondary byte
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= '0;
    end else begin
      cmd_valid_reg <= atn_byte && state_reg == ST_SECONDARY &&
                       bus.ctl_data[7:5] == gpib_pkg::SECONDARY_PREFIX &&
                       known_code(bus.ctl_data[4:0]);
      if (atn_byte && state_reg == ST_SECONDARY) begin
        cmd_code_reg <= bus.ctl_data[4:0];
      end
    end
  end

  // Decimal parameter; non-digits other than CR are skipped
  always_ff @(posedge clk) begin
    if (srst) begin
      param_reg <= gpib_pkg::PARAM_RESET;
      param_valid_reg <= 1'b0;
    end else begin
      param_valid_reg <= 1'b0;
      if (atn_byte) begin
        param_reg <= gpib_pkg::PARAM_RESET;
      end else if (data_byte && state_reg == ST_PARAM && listen_reg) begin
        if (bus.ctl_data >= gpib_pkg::DIGIT_ZERO && bus.ctl_data <= gpib_pkg::DIGIT_NINE &&
            !(bus.ctl_eoi && bus.ctl_data == gpib_pkg::CR_BYTE)) begin
          param_reg <= 16'(param_reg * 16'h000A + 16'(bus.ctl_data - gpib_pkg::DIGIT_ZERO));
        end
        if (bus.ctl_eoi || bus.ctl_data == gpib_pkg::CR_BYTE) begin
          param_valid_reg <= 1'b1;
        end
      end
    end
  end

  // Plain listener data once no parameter is pending
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= '0;
      rx_eoi_reg <= 1'b0;
    end else begin
      rx_valid_reg <= data_byte && listen_reg && state_reg != ST_PARAM;
      if (data_byte) begin
        rx_data_reg <= bus.ctl_data;
        rx_eoi_reg <= bus.ctl_eoi;
      end
    end
  end

  talk_fifo #(
    .WIDTH(gpib_pkg::FIFO_WIDTH),
    .DEPTH(gpib_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_data({talk_last, talk_data}),
    .in_valid(talk_valid),
    .in_ready(talk_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Output stage; refills only while talking and ATN is not held
  assign tx_take = tx_valid_reg && bus.ctl_ready;
  assign fifo_pop = talk_reg && !(bus.ctl_valid && bus.ctl_atn) &&
                    (!tx_valid_reg || tx_take);

  always_ff @(posedge clk) begin
    // Untalk empties the stage at once, so no byte slips out after it
    if (srst || !talk_reg || (atn_byte && bus.ctl_data == gpib_pkg::UNTALK_BYTE)) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= '0;
      tx_eoi_reg <= 1'b0;
    end else if (fifo_pop) begin
      tx_valid_reg <= fifo_valid;
      tx_data_reg <= fifo_out[7:0];
      tx_eoi_reg <= fifo_out[8];
    end else if (tx_take) begin
      tx_valid_reg <= 1'b0;
    end
  end

  assign bus.dev_valid = tx_valid_reg;
  assign bus.dev_data = tx_data_reg;
  assign bus.dev_eoi = tx_eoi_reg;
  assign bus.dev_ready = 1'b1;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_code = cmd_code_reg;
  assign param_valid = param_valid_reg;
  assign param_value = param_reg;
  assign rx_valid = rx_valid_reg;
  assign rx_data = rx_data_reg;
  assign rx_eoi = rx_eoi_reg;
  assign is_talker = talk_reg;
  assign is_listener = listen_reg;
endmodule

/* rtl/bus_controller_end.sv */
`timescale 1ns/1ps
module bus_controller_end (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus side
  gpib_link_if.controller bus
);
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic tx_valid_reg, tx_atn_reg, tx_eoi_reg;
  logic [7:0] tx_data_reg;
  logic rx_full_reg, rx_eoi_reg;
  logic [7:0] rx_data_reg;
  logic access, wr_tx, rd_rx, rx_take;

  // Answer lands one cycle into the access phase
  assign access = psel && penable && !pready_reg;
  assign wr_tx = access && pwrite && paddr == gpib_pkg::REG_TX_OFFSET;
  assign rd_rx = access && !pwrite && paddr == gpib_pkg::REG_RX_OFFSET;
  assign rx_take = bus.dev_valid && !rx_full_reg;

  // APB answer, unmapped offsets flag an error
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && paddr != gpib_pkg::REG_TX_OFFSET &&
                     paddr != gpib_pkg::REG_STATUS_OFFSET && paddr != gpib_pkg::REG_RX_OFFSET;
      prdata_reg <= '0;
      if (access && !pwrite) begin
        case (paddr)
          gpib_pkg::REG_STATUS_OFFSET: begin
            prdata_reg[gpib_pkg::ST_TX_BUSY_BIT] <= tx_valid_reg;
            prdata_reg[gpib_pkg::ST_RX_VALID_BIT] <= rx_full_reg;
          end
          gpib_pkg::REG_RX_OFFSET: begin
            prdata_reg <= {23'h000000, rx_eoi_reg, rx_data_reg};
          end
          default: begin
            prdata_reg <= '0;
          end
        endcase
      end
    end
  end

  // One byte outstanding; a write while busy is dropped, poll status first
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_valid_reg <= 1'b0;
      tx_atn_reg <= 1'b0;
      tx_eoi_reg <= 1'b0;
      tx_data_reg <= '0;
    end else if (wr_tx && !tx_valid_reg) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= pwdata[7:0];
      tx_atn_reg <= pwdata[gpib_pkg::TX_ATN_BIT];
      tx_eoi_reg <= pwdata[gpib_pkg::TX_EOI_BIT];
    end else if (tx_valid_reg && bus.dev_ready) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // Received byte slot; a pop and a new byte may meet, new byte wins
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_full_reg <= 1'b0;
      rx_eoi_reg <= 1'b0;
      rx_data_reg <= '0;
    end else if (rx_take) begin
      rx_full_reg <= 1'b1;
      rx_data_reg <= bus.dev_data;
      rx_eoi_reg <= bus.dev_eoi;
    end else if (rd_rx) begin
      rx_full_reg <= 1'b0;
    end
  end

  assign bus.ctl_valid = tx_valid_reg;
  assign bus.ctl_data = tx_data_reg;
  assign bus.ctl_atn = tx_atn_reg;
  assign bus.ctl_eoi = tx_eoi_reg;
  assign bus.ctl_ready = !rx_full_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

/* dv/gpib_link_chk.sv */
`timescale 1ns/1ps
module gpib_link_chk #(
  parameter logic [4:0] ADDR = 5'h10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Controller to drive
  input wire logic [7:0] ctl_data,
  input wire logic ctl_atn,
  input wire logic ctl_eoi,
  input wire logic ctl_valid,
  input wire logic dev_ready,
  // Drive to controller
  input wire logic [7:0] dev_data,
  input wire logic dev_eoi,
  input wire logic dev_valid,
  input wire logic ctl_ready
);
  logic cmd_byte;
  logic talk_seen_reg;

  // Command byte on the wire
  assign cmd_byte = ctl_valid && ctl_atn;

  // Talker state as the wire implies it; one-sided, so only extra sending is flagged
  always_ff @(posedge clk) begin
    if (srst)
      talk_seen_reg <= 1'h0;
    else if (cmd_byte && ctl_data == {gpib_pkg::TALK_PREFIX, ADDR})
      talk_seen_reg <= 1'h1;
    else if (cmd_byte && ctl_data == gpib_pkg::UNTALK_BYTE)
      talk_seen_reg <= 1'h0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  chk_talk_gate: assert property (dev_valid |-> talk_seen_reg)
    else $error("drive sends without its talk address");
  chk_reset_idle: assert property ($fell(srst) |-> !dev_valid && !ctl_valid && ctl_ready)
    else $error("link not idle after reset");
  chk_ready_high: assert property (dev_ready)
    else $error("drive refuses a byte");
  chk_ctl_pulse: assert property (ctl_valid |=> !ctl_valid)
    else $error("controller byte longer than one cycle");
  chk_atn_no_refill: assert property (cmd_byte && !dev_valid |=> !dev_valid)
    else $error("drive refilled during a command byte");
  chk_untalk_stop: assert property (
    cmd_byte && ctl_data == gpib_pkg::UNTALK_BYTE |=> !dev_valid [*3])
    else $error("drive still sends after untalk");
  chk_valid_hold: assert property (
    dev_valid && !ctl_ready && !cmd_byte |=> dev_valid && $stable(dev_data) && $stable(dev_eoi))
    else $error("drive byte changed before it was taken");
  chk_unlisten_keeps: assert property (
    dev_valid && !ctl_ready && cmd_byte && ctl_data == gpib_pkg::UNLISTEN_BYTE |=> dev_valid)
    else $error("unlisten dropped the talker byte");
endmodule

/* dv/gpib_secondary_command_decoder_tb.sv */
`timescale 1ns/1ps
module gpib_secondary_command_decoder_tb;
  localparam logic [4:0] ADDR = 5'h10;
  localparam logic [7:0] MLA = {gpib_pkg::LISTEN_PREFIX, ADDR};
  localparam logic [7:0] MTA = {gpib_pkg::TALK_PREFIX, ADDR};
  localparam logic [7:0] UNL = gpib_pkg::UNLISTEN_BYTE;
  localparam logic [31:0] DECODED = 32'h7F00_F2D7;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_data, talk_data;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] cmd_code, cmd_last;
  logic remote_sw, proto_sw, cmd_valid, param_valid, rx_valid, rx_eoi;
  logic [15:0] param_value, param_last;
  logic [8:0] rx_last;
  logic [4:0] addr_sw;
  logic talk_last, talk_valid, talk_ready, is_talker, is_listener;
  int errors, comparisons, cmd_cnt, n;

  gpib_link_if u_gpib_link_if ();
  bus_controller_end u_bus_controller_end (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(u_gpib_link_if.controller));
  tape_drive_end #(.HAS_PROTOCOL_OPTION(1'h1)) u_tape_drive_end (.clk(clk), .srst(srst),
    .bus(u_gpib_link_if.drive), .device_address_switches(addr_sw),
    .remote_select_switch(remote_sw), .protocol_select_switch(proto_sw),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_valid(param_valid),
    .param_value(param_value), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi),
    .talk_data(talk_data), .talk_last(talk_last), .talk_valid(talk_valid),
    .talk_ready(talk_ready), .is_talker(is_talker), .is_listener(is_listener));
  gpib_link_chk #(.ADDR(ADDR)) u_gpib_link_chk (.clk(clk), .srst(srst),
    .ctl_data(u_gpib_link_if.ctl_data), .ctl_atn(u_gpib_link_if.ctl_atn),
    .ctl_eoi(u_gpib_link_if.ctl_eoi), .ctl_valid(u_gpib_link_if.ctl_valid),
    .dev_ready(u_gpib_link_if.dev_ready), .dev_data(u_gpib_link_if.dev_data),
    .dev_eoi(u_gpib_link_if.dev_eoi), .dev_valid(u_gpib_link_if.dev_valid),
    .ctl_ready(u_gpib_link_if.ctl_ready));

  // Clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Executor pulses last one cycle, so catch them at every edge
  always @(posedge clk) begin
    if (cmd_valid === 1'h1) begin
      cmd_cnt <= cmd_cnt + 1;
      cmd_last <= cmd_code;
    end
    if (param_valid === 1'h1)
      param_last <= param_value;
    if (rx_valid === 1'h1)
      rx_last <= {rx_eoi, rx_data};
  end

  task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; the leading edge keeps back-to-back calls from double driving
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Send one bus byte and wait until the controller is free again
  task sb(input logic [7:0] b, input logic atn, input logic eoi);
    apb(1'h1, gpib_pkg::REG_TX_OFFSET, {22'h0, eoi, atn, b});
    do apb(1'h0, gpib_pkg::REG_STATUS_OFFSET, 32'h0);
    while (q[gpib_pkg::ST_TX_BUSY_BIT] !== 1'h0);
    repeat (3) @(posedge clk);
  endtask

  task rxpop;
    do apb(1'h0, gpib_pkg::REG_STATUS_OFFSET, 32'h0);
    while (q[gpib_pkg::ST_RX_VALID_BIT] !== 1'h1);
    apb(1'h0, gpib_pkg::REG_RX_OFFSET, 32'h0);
  endtask

  task push(input logic [7:0] d, input logic last);
    @(posedge clk);
    talk_data <= d;
    talk_last <= last;
    talk_valid <= 1'h1;
    do @(posedge clk); while (talk_ready !== 1'h1);
    talk_valid <= 1'h0;
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    #1_200_000;
    errors++;
    summarize;
  end

  initial begin
    srst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {talk_data, talk_last, talk_valid, proto_sw} = '0;
    remote_sw = 1'h1;
    addr_sw = ADDR;
    {errors, comparisons, cmd_cnt, cmd_last, param_last, rx_last} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    repeat (8) @(posedge clk);
    // Unmapped offset is refused
    apb(1'h0, 8'h0C, 32'h0);
    check_bit("unmapped pslverr", 1'h1, err);
    // Find file 15, ended by CR
    sb(MLA, 1'h1, 1'h0);
    check_bit("is_listener", 1'h1, is_listener);
    sb(8'h78, 1'h1, 1'h0);
    check_val("find code", gpib_pkg::CMD_FIND, cmd_last);
    sb(8'h31, 1'h0, 1'h0);
    sb(8'h35, 1'h0, 1'h0);
    sb(gpib_pkg::CR_BYTE, 1'h0, 1'h0);
    check_val("param cr", 32'hF, param_last);
    sb(8'h5A, 1'h0, 1'h1);
    check_val("rx byte", 32'h15A, rx_last);
    sb(UNL, 1'h1, 1'h0);
    check_bit("unlisten", 1'h0, is_listener);
    // Same command, string ended by EOI on the last digit
    sb(MLA, 1'h1, 1'h0);
    sb(8'h78, 1'h1, 1'h0);
    sb(8'h37, 1'h0, 1'h0);
    sb(8'h33, 1'h0, 1'h1);
    check_val("param eoi", 32'h49, param_last);
    sb(UNL, 1'h1, 1'h0);
    // Every secondary code; a set bit in the mask marks a decoded one
    for (int c = 0; c < 32; c++) begin
      n = cmd_cnt;
      sb(MLA, 1'h1, 1'h0);
      sb({gpib_pkg::SECONDARY_PREFIX, c[4:0]}, 1'h1, 1'h0);
      check_val("cmd count", n + DECODED[c], cmd_cnt);
      if (DECODED[c])
        check_val("cmd code", c, cmd_last);
      sb(UNL, 1'h1, 1'h0);
    end
    // Foreign address, no ATN, off line, alternate protocol: all ignored
    for (int m = 0; m < 4; m++) begin
      n = cmd_cnt;
      remote_sw <= (m != 2);
      proto_sw <= (m == 3);
      repeat (8) @(posedge clk);
      sb((m == 0) ? MLA + 8'h1 : MLA, m != 1, 1'h0);
      sb(8'h78, m != 1, 1'h0);
      check_val("ignored cmd", n, cmd_cnt);
      check_bit("ignored listen", 1'h0, is_listener);
    end
    remote_sw <= 1'h1;
    proto_sw <= 1'h0;
    repeat (8) @(posedge clk);
    // New switch setting moves the listen address
    addr_sw <= 5'h01;
    repeat (8) @(posedge clk);
    sb(MLA, 1'h1, 1'h0);
    check_bit("old address", 1'h0, is_listener);
    sb(8'h21, 1'h1, 1'h0);
    check_bit("address one", 1'h1, is_listener);
    sb(UNL, 1'h1, 1'h0);
    addr_sw <= ADDR;
    repeat (8) @(posedge clk);
    // Fill the talk buffer until it refuses, then talk it out with a stalled reader
    for (int i = 0; i < 16; i++)
      push(8'h41 + i[7:0], i == 15);
    @(posedge clk);
    check_bit("fifo full", 1'h0, talk_ready);
    sb(MTA, 1'h1, 1'h0);
    check_bit("is_talker", 1'h1, is_talker);
    for (int i = 0; i < 16; i++) begin
      rxpop;
      check_val("talk byte", {23'h0, i == 15, 8'h41 + i[7:0]}, q);
      if (i == 3)
        sb(UNL, 1'h1, 1'h0);
    end
    // Untalk in mid-transfer stops the drive
    for (int i = 0; i < 4; i++)
      push(8'h61 + i[7:0], 1'h0);
    sb(gpib_pkg::UNTALK_BYTE, 1'h1, 1'h0);
    check_bit("untalk", 1'h0, is_talker);
    apb(1'h0, gpib_pkg::REG_STATUS_OFFSET, 32'h0);
    if (q[gpib_pkg::ST_RX_VALID_BIT] === 1'h1)
      apb(1'h0, gpib_pkg::REG_RX_OFFSET, 32'h0);
    repeat (20) @(posedge clk);
    apb(1'h0, gpib_pkg::REG_STATUS_OFFSET, 32'h0);
    check_bit("byte after untalk", 1'h0, q[gpib_pkg::ST_RX_VALID_BIT]);
    summarize;
  end
endmodule
